/* File: core_consts.vh */
`ifndef CORE_CONSTS_VH
`define CORE_CONSTS_VH

// ==========================================================
// Register map (word index, byte address = index * 4)
// ==========================================================
`define REG_INSTR       4'h0
`define REG_WORK        4'h1
`define REG_STATUS      4'h2
`define REG_BANK        4'h3
`define REG_CFG         4'h4
`define REG_PTR0        4'h5
`define REG_PTR1        4'h6
`define REG_PTR2        4'h7
`define REG_TABLE_POINTER_REG      4'h8
`define REG_TBLLAT      4'h9
`define REG_FILE_ADDR   4'ha
`define REG_FILE_DATA   4'hb
`define REG_RET_ADDR    4'hc
`define REG_PC          4'hd

// ==========================================================
// Field positions and reset values
// ==========================================================
`define STATUS_Z_BIT    2
`define STATUS_N_BIT    4
`define CFG_EXT_BIT     0
`define CFG_EXT_RESET   1'b1
`define CFG_SECOND_BIT  1
`define ILO_MAX_ADDR    8'h5f
`define ACCESS_SPLIT    8'h60
`define UNMAPPED_DATA   32'h0000_0000

// ==========================================================
// Opcode patterns
// ==========================================================
`define OP_TEST_FILE_SKIP_ZERO_HI    7'h33
`define OP_XOR_WORK_WITH_FILE_HI     6'h06
`define OP_XOR_LITERAL_INTO_WORK_HI     8'h0a
`define OP_TABLE_WRITE_OP_HI     14'h0003
`define OP_FSRADD_HI    8'he8
`define OP_FSRSUB_HI    8'he9

// ==========================================================
// Timing
// ==========================================================
`define CYCLE_NS        8
`define INSTR_CYCLES    4

`endif

/* File: operand_addr.v */
`timescale 1ns/10ps
`default_nettype none
`include "core_consts.vh"

module operand_addr (
    input  wire        access_sel_i,   // Access-select bit of instruction
    input  wire [7:0]  file_addr_i,    // 8-bit file field
    input  wire [3:0]  bank_sel_i,     // Bank select register
    input  wire        ext_en_i,       // Extended set enabled
    input  wire [11:0] ptr2_i,         // Third pointer, index base
    output wire [11:0] data_addr_o,    // Resolved data address
    output wire        indexed_o       // Indexed literal offset used
);
    // Indexed mode overrides access bank for low addresses only
    assign indexed_o   = ~access_sel_i & ext_en_i & (file_addr_i <= `ILO_MAX_ADDR);
    assign data_addr_o = indexed_o ? (ptr2_i + {4'h0, file_addr_i}) :
                         access_sel_i ? {bank_sel_i, file_addr_i} :
                         (file_addr_i < `ACCESS_SPLIT) ? {4'h0, file_addr_i} :
                         {4'hf, file_addr_i};
endmodule
`default_nettype wire

/* File: data_ram.v */
`timescale 1ns/10ps
`default_nettype none

module data_ram (
    input  wire        clk_i,    // Core clock
    input  wire        we_i,     // Write enable
    input  wire [11:0] waddr_i,  // Write address
    input  wire [7:0]  wdata_i,  // Write data
    input  wire [11:0] raddr_i,  // Read address
    output wire [7:0]  rdata_o   // Asynchronous read data
);
    reg [7:0] mem [0:4095];
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
    assign rdata_o = mem[raddr_i];
endmodule
`default_nettype wire

/* File: xor_test_core.v */
// Operation
// - Decode test-skip-zero from 0110011a ffffffff.
// - Zero operand discards prefetched instruction; one no-op cycle follows.
// - Skipped two-word instruction costs two no-op cycles, three total.
// - Access bit zero selects access bank; one uses bank select register.
// - Access zero, extended enabled, address up to 95: indexed literal offset.
// - Decode register xor from 000110da ffffffff.
// - Register xor writes W when d is zero, file when one.
// - Both xor forms update only negative and zero flags.
// - Extension adds pointer instructions and indexed offset addressing.
// - Extended set enabled by default; configuration bit disables it.
// - Extended instructions are literal pointer operations.
// - Pointer add/sub on third pointer may return automatically.
// - Table write updates pointer: none, post-inc, post-dec, pre-inc.
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "core_consts.vh"

module xor_test_core (
    input  wire        clk_i,            // 125 MHz core clock
    input  wire        srst_i,           // Synchronous reset, active high
    input  wire [5:0]  avs_address_i,    // Word address
    input  wire        avs_read_i,       // Read request
    input  wire        avs_write_i,      // Write request
    input  wire [31:0] avs_writedata_i,  // Write data
    input  wire [3:0]  avs_byteenable_i, // Byte enables
    output reg  [31:0] avs_readdata_o,   // Read data
    output wire        avs_waitrequest_o,// Wait request
    output wire        busy_o            // Instruction executing
);
    // ==========================================================
    // State
    // ==========================================================
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_EXEC = 4'b0010;
    localparam [3:0] S_NOP  = 4'b0100;
    localparam [3:0] S_DONE = 4'b1000;

    reg  [3:0]  state;
    reg  [1:0]  quarter;
    reg         nop_left;
    reg  [15:0] instr;
    reg  [7:0]  work;
    reg  [7:0]  status;
    reg  [3:0]  bank_sel;
    reg         ext_en;
    reg         next_two_word;
    reg  [11:0] ptr [0:2];
    reg  [21:0] tbl_ptr;
    reg  [7:0]  tbl_lat;
    reg  [11:0] dbg_addr;
    reg  [20:0] ret_addr;
    reg  [20:0] pc;
    reg         acc_done;
    reg         ram_we_dbg;

    wire [11:0] op_addr;
    wire        op_indexed;
    wire [7:0]  ram_rdata;
    wire [7:0]  file_val = ram_rdata;

    // ==========================================================
    // Decode
    // ==========================================================
    function [2:0] decode;
        input [15:0] w;
        begin
            if (w[15:9] == `OP_TEST_FILE_SKIP_ZERO_HI)      decode = 3'h1;
            else if (w[15:10] == `OP_XOR_WORK_WITH_FILE_HI) decode = 3'h2;
            else if (w[15:8] == `OP_XOR_LITERAL_INTO_WORK_HI)  decode = 3'h3;
            else if (w[15:2] == `OP_TABLE_WRITE_OP_HI)  decode = 3'h4;
            else if (w[15:8] == `OP_FSRADD_HI) decode = 3'h5;
            else if (w[15:8] == `OP_FSRSUB_HI) decode = 3'h6;
            else                               decode = 3'h0;
        end
    endfunction

    wire [2:0] kind      = decode(instr);
    wire       bus_sel   = avs_read_i | avs_write_i;
    // Writes land on the accept edge, where waitrequest is already low
    wire       reg_wr    = avs_write_i & acc_done & (state == S_IDLE);
    wire       instr_wr  = reg_wr & (avs_address_i == {2'b00, `REG_INSTR});
    wire [7:0] xor_res   = work ^ ((kind == 3'h3) ? instr[7:0] : file_val);
    wire       skip      = (kind == 3'h1) & (file_val == 8'h00);
    wire       last_q    = (state == S_EXEC) & (quarter == 2'd3);
    wire       ext_kind  = (kind == 3'h5) | (kind == 3'h6);
    wire [1:0] fsel      = instr[7:6];
    wire [5:0] lit6      = instr[5:0];

    // ==========================================================
    // Return variants
    // ==========================================================
    // Select code 3 of pointer add/sub works on the third pointer and
    // then jumps to the saved return address instead of falling through
    wire        ret_variant = ext_en & ext_kind & (fsel == 2'd3);
    reg  [20:0] next_pc;

    always @* begin
        next_pc = pc + 21'd2;
        if (ret_variant) begin
            next_pc = ret_addr;
        end
    end

    // ==========================================================
    // Operand path and data memory
    // ==========================================================
    operand_addr u_addr (
        .access_sel_i (instr[8]),
        .file_addr_i  (instr[7:0]),
        .bank_sel_i   (bank_sel),
        .ext_en_i     (ext_en),
        .ptr2_i       (ptr[2]),
        .data_addr_o  (op_addr),
        .indexed_o    (op_indexed)
    );

    wire ram_we = (last_q & (kind == 3'h2) & instr[9]) | ram_we_dbg;
    data_ram u_ram (
        .clk_i   (clk_i),
        .we_i    (ram_we),
        .waddr_i (ram_we_dbg ? dbg_addr : op_addr),
        .wdata_i (ram_we_dbg ? avs_writedata_i[7:0] : xor_res),
        .raddr_i ((state == S_IDLE) ? dbg_addr : op_addr),
        .rdata_o (ram_rdata)
    );

    // ==========================================================
    // Bus slave: one wait cycle on every access
    // ==========================================================
    assign avs_waitrequest_o = bus_sel & ~acc_done;
    assign busy_o            = (state != S_IDLE);

    always @(posedge clk_i) begin
        if (srst_i) begin
            acc_done <= 1'b0;
        end else begin
            acc_done <= bus_sel & ~acc_done;
        end
    end

    always @* begin
        ram_we_dbg = reg_wr & (avs_address_i == {2'b00, `REG_FILE_DATA}) & avs_byteenable_i[0];
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            avs_readdata_o <= `UNMAPPED_DATA;
        // Captured in the wait cycle so the data stands at the accept edge
        end else if (avs_read_i & ~acc_done) begin
            case (avs_address_i)
                {2'b00, `REG_INSTR}:     avs_readdata_o <= {16'h0000, instr};
                {2'b00, `REG_WORK}:      avs_readdata_o <= {24'h0, work};
                {2'b00, `REG_STATUS}:    avs_readdata_o <= {23'h0, busy_o, status};
                {2'b00, `REG_BANK}:      avs_readdata_o <= {28'h0, bank_sel};
                {2'b00, `REG_CFG}:       avs_readdata_o <= {29'h0, op_indexed, next_two_word, ext_en};
                {2'b00, `REG_PTR0}:      avs_readdata_o <= {20'h0, ptr[0]};
                {2'b00, `REG_PTR1}:      avs_readdata_o <= {20'h0, ptr[1]};
                {2'b00, `REG_PTR2}:      avs_readdata_o <= {20'h0, ptr[2]};
                {2'b00, `REG_TABLE_POINTER_REG}:    avs_readdata_o <= {10'h0, tbl_ptr};
                {2'b00, `REG_TBLLAT}:    avs_readdata_o <= {24'h0, tbl_lat};
                {2'b00, `REG_FILE_ADDR}: avs_readdata_o <= {20'h0, dbg_addr};
                {2'b00, `REG_FILE_DATA}: avs_readdata_o <= {24'h0, ram_rdata};
                {2'b00, `REG_RET_ADDR}:  avs_readdata_o <= {11'h0, ret_addr};
                {2'b00, `REG_PC}:        avs_readdata_o <= {11'h0, pc};
                default:                 avs_readdata_o <= `UNMAPPED_DATA;
            endcase
        end
    end

    // ==========================================================
    // Execution sequencer: four quarters per instruction cycle
    // ==========================================================
    always @(posedge clk_i) begin
        if (srst_i) begin
            state    <= S_IDLE;
            quarter  <= 2'd0;
            nop_left <= 1'b0;
            instr    <= 16'h0000;
            pc       <= 21'h0;
        end else begin
            case (state)
                S_IDLE: begin
                    quarter <= 2'd0;
                    if (instr_wr) begin
                        instr <= avs_writedata_i[15:0];
                        state <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    quarter <= quarter + 2'd1;
                    if (last_q) begin
                        pc <= next_pc;
                        if (skip) begin
                            // Discarded word(s) still consume fetch slots
                            nop_left <= next_two_word;
                            state    <= S_NOP;
                        end else begin
                            state <= S_DONE;
                        end
                    end
                end
                S_NOP: begin
                    // Each discarded word costs one whole no-op cycle
                    quarter <= quarter + 2'd1;
                    if (quarter == 2'd3) begin
                        pc <= pc + 21'd2;
                        if (nop_left) begin
                            nop_left <= 1'b0;
                        end else begin
                            state <= S_DONE;
                        end
                    end
                end
                S_DONE: begin
                    // One settle cycle so busy falls after the last writes
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Architectural registers
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ptr
            localparam integer PTR_ADDR = `REG_PTR0 + g;
            localparam integer PTR_IDX  = g;
            // Return variants carry select code 3 but step the third pointer
            wire step = last_q & ext_en & ext_kind
                        & ((fsel == PTR_IDX[1:0]) | ((PTR_IDX == 2) & ret_variant));
            always @(posedge clk_i) begin
                if (srst_i) begin
                    ptr[g] <= 12'h000;
                end else if (reg_wr & (avs_address_i == PTR_ADDR[5:0])) begin
                    ptr[g] <= avs_writedata_i[11:0];
                end else if (step) begin
                    ptr[g] <= (kind == 3'h5) ? ptr[g] + {6'h0, lit6}
                                             : ptr[g] - {6'h0, lit6};
                end
            end
        end
    endgenerate

    always @(posedge clk_i) begin
        if (srst_i) begin
            work          <= 8'h00;
            status        <= 8'h00;
            bank_sel      <= 4'h0;
            ext_en        <= `CFG_EXT_RESET;
            next_two_word <= 1'b0;
            tbl_ptr       <= 22'h0;
            tbl_lat       <= 8'h00;
            dbg_addr      <= 12'h000;
            ret_addr      <= 21'h0;
        end else if (reg_wr) begin
            case (avs_address_i)
                {2'b00, `REG_WORK}:      work <= avs_writedata_i[7:0];
                {2'b00, `REG_STATUS}:    status <= avs_writedata_i[7:0];
                {2'b00, `REG_BANK}:      bank_sel <= avs_writedata_i[3:0];
                {2'b00, `REG_CFG}: begin
                    ext_en        <= avs_writedata_i[`CFG_EXT_BIT];
                    next_two_word <= avs_writedata_i[`CFG_SECOND_BIT];
                end
                {2'b00, `REG_TABLE_POINTER_REG}:    tbl_ptr <= avs_writedata_i[21:0];
                {2'b00, `REG_TBLLAT}:    tbl_lat <= avs_writedata_i[7:0];
                {2'b00, `REG_FILE_ADDR}: dbg_addr <= avs_writedata_i[11:0];
                {2'b00, `REG_RET_ADDR}:  ret_addr <= avs_writedata_i[20:0];
                default: begin
                end
            endcase
        end else if (last_q) begin
            if ((kind == 3'h3) | ((kind == 3'h2) & ~instr[9])) begin
                work <= xor_res;
            end
            if ((kind == 3'h2) | (kind == 3'h3)) begin
                status[`STATUS_Z_BIT] <= (xor_res == 8'h00);
                status[`STATUS_N_BIT] <= xor_res[7];
            end
            // Pre-increment leaves the same final pointer as post-increment
            if (kind == 3'h4) begin
                case (instr[1:0])
                    2'd1:    tbl_ptr <= tbl_ptr + 22'd1;
                    2'd2:    tbl_ptr <= tbl_ptr - 22'd1;
                    2'd3:    tbl_ptr <= tbl_ptr + 22'd1;
                    default: tbl_ptr <= tbl_ptr;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* File: xor_test_core_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "core_consts.vh"

module xor_test_core_monitor (
    input wire logic        clk_i,             // Core clock
    input wire logic        srst_i,            // Synchronous reset
    input wire logic [5:0]  avs_address_i,     // Word address
    input wire logic        avs_read_i,        // Read request
    input wire logic        avs_write_i,       // Write request
    input wire logic [31:0] avs_writedata_i,   // Write data
    input wire logic [3:0]  avs_byteenable_i,  // Byte enables
    input wire logic [31:0] avs_readdata_o,    // Read data
    input wire logic        avs_waitrequest_o, // Wait request
    input wire logic        busy_o             // Instruction executing
);
    // ==========================================================
    // Helper state
    // ==========================================================
    logic       cfg_wr;
    logic       bank_wr;
    logic [3:0] bank_shadow;
    wire        req   = avs_read_i | avs_write_i;
    wire        done  = req & ~avs_waitrequest_o;
    wire        instr = done & avs_write_i & (avs_address_i == {2'b00, `REG_INSTR});

    always @(posedge clk_i) begin
        if (srst_i) begin
            cfg_wr      <= 1'b0;
            bank_wr     <= 1'b0;
            bank_shadow <= 4'h0;
        end else if (done && avs_write_i) begin
            if (avs_address_i == {2'b00, `REG_CFG})
                cfg_wr <= 1'b1;
            if (avs_address_i == {2'b00, `REG_BANK}) begin
                bank_wr     <= 1'b1;
                bank_shadow <= avs_writedata_i[3:0];
            end
        end
    end

    // ==========================================================
    // Properties
    // ==========================================================
    property p_wait_first;
        @(posedge clk_i) disable iff (srst_i) $rose(req) |-> avs_waitrequest_o;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("request not held off first cycle");

    property p_wait_one;
        @(posedge clk_i) disable iff (srst_i) req && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait request held too long");

    property p_idle_nowait;
        @(posedge clk_i) disable iff (srst_i) !req |-> !avs_waitrequest_o;
    endproperty
    a_idle_nowait: assert property (p_idle_nowait) else $error("wait request without request");

    property p_unmapped;
        @(posedge clk_i) disable iff (srst_i)
            done && avs_read_i && avs_address_i > 6'h0d |-> avs_readdata_o == `UNMAPPED_DATA;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_cfg_reset;
        @(posedge clk_i) disable iff (srst_i) done && avs_read_i && !cfg_wr
            && avs_address_i == {2'b00, `REG_CFG} |-> avs_readdata_o[0] == `CFG_EXT_RESET;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("extension not enabled at reset");

    property p_bank_rb;
        @(posedge clk_i) disable iff (srst_i) done && avs_read_i && bank_wr
            && avs_address_i == {2'b00, `REG_BANK} |-> avs_readdata_o[3:0] == bank_shadow;
    endproperty
    a_bank_rb: assert property (p_bank_rb) else $error("bank select readback wrong");

    property p_busy_bound;
        @(posedge clk_i) disable iff (srst_i) $rose(busy_o) |-> ##[1:40] !busy_o;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("instruction never finished");

    property p_busy_cause;
        @(posedge clk_i) disable iff (srst_i) $rose(busy_o) |-> $past(instr, 1) || $past(instr, 2);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without instruction");
endmodule

bind xor_test_core xor_test_core_monitor mon_u (
    .clk_i             (clk_i),
    .srst_i            (srst_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .busy_o            (busy_o)
);
`default_nettype wire

/* File: xor_test_core_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "core_consts.vh"

module xor_test_core_bench;
    logic        clk_i            = 1'b0;
    logic        srst_i           = 1'b1;
    logic [5:0]  avs_address_i    = 6'h00;
    logic        avs_read_i       = 1'b0;
    logic        avs_write_i      = 1'b0;
    logic [31:0] avs_writedata_i  = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hf;
    wire  [31:0] avs_readdata_o;
    wire         avs_waitrequest_o;
    wire         busy_o;
    int          error_cnt        = 0;
    int          checks_done      = 0;
    logic [31:0] rd;
    logic [31:0] pc0;
    logic [31:0] dl[3];
    int          cyc[3];
    int          ncyc;
    logic [31:0] tb_exp[4] = '{32'ha356, 32'ha357, 32'ha356, 32'ha357};
    logic [7:0]  lw_w[3] = '{8'hb5, 8'h5a, 8'h00};
    logic [7:0]  lw_k[3] = '{8'haf, 8'h5a, 8'h80};
    // Bank, access bit, dest bit, file field, config, resolved address
    logic [3:0]  xb[6]   = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2};
    logic        xa[6]   = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    logic        xd[6]   = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [7:0]  xf[6]   = '{8'h10, 8'h80, 8'h05, 8'h05, 8'h5f, 8'h60};
    logic [31:0] xc[6]   = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h1, 32'h1};
    logic [31:0] xe[6]   = '{32'h210, 32'hf80, 32'h305, 32'h005, 32'h35f, 32'hf60};

    always #4 clk_i = ~clk_i;

    xor_test_core dut_u (
        .clk_i             (clk_i),
        .srst_i            (srst_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .busy_o            (busy_o)
    );

    // ==========================================================
    // Bus and check tasks
    // ==========================================================
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask

    // Request held until wait request is sampled low at an edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= ~w;
        avs_write_i     <= w;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, {2'b00, i}, d, q);
    endtask

    task automatic rchk(input logic [3:0] i, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, {2'b00, i}, 32'h0, q);
        cmp(q & m, e & m);
    endtask

    task automatic fset(input logic [31:0] a, input logic [31:0] d);
        wr(`REG_FILE_ADDR, a);
        wr(`REG_FILE_DATA, d);
    endtask

    task automatic exec(input logic [15:0] ins);
        int n;
        n = 0;
        wr(`REG_INSTR, {16'h0, ins});
        do begin
            @(posedge clk_i);
            n++;
        end while (busy_o !== 1'b0 && n < 60);
        if (n >= 60) begin
            error_cnt++;
            $display("unexpected at %0t: instruction hung", $time);
        end
        ncyc = n;
    endtask

    function automatic logic [31:0] stat_exp(input logic [7:0] r);
        return 32'h3 | ({31'h0, r == 8'h0} << `STATUS_Z_BIT) | ({31'h0, r[7]} << `STATUS_N_BIT);
    endfunction

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        rchk(`REG_CFG, 32'h1, 32'h1);
        bus(1'b0, 6'h3f, 32'h0, rd);
        cmp(rd, `UNMAPPED_DATA);
        $display("test reset finished");
        for (int i = 0; i < 3; i++) begin
            wr(`REG_WORK, {24'h0, lw_w[i]});
            wr(`REG_STATUS, 32'h7);
            exec({`OP_XOR_LITERAL_INTO_WORK_HI, lw_k[i]});
            rchk(`REG_WORK, 32'hff, {24'h0, lw_w[i] ^ lw_k[i]});
            rchk(`REG_STATUS, 32'hff, stat_exp(lw_w[i] ^ lw_k[i]));
        end
        $display("test literal xor finished");
        wr(`REG_PTR2, 32'h300);
        for (int i = 0; i < 6; i++) begin
            wr(`REG_BANK, {28'h0, xb[i]});
            wr(`REG_CFG, xc[i]);
            rchk(`REG_BANK, 32'hf, {28'h0, xb[i]});
            fset(xe[i], 32'haf);
            wr(`REG_WORK, 32'hb5);
            wr(`REG_STATUS, 32'h7);
            exec({`OP_XOR_WORK_WITH_FILE_HI, xd[i], xa[i], xf[i]});
            rchk(`REG_WORK, 32'hff, xd[i] ? 32'hb5 : 32'h1a);
            wr(`REG_FILE_ADDR, xe[i]);
            rchk(`REG_FILE_DATA, 32'hff, xd[i] ? 32'h1a : 32'haf);
            rchk(`REG_STATUS, 32'hff, stat_exp(8'h1a));
        end
        $display("test file xor finished");
        wr(`REG_BANK, 32'h1);
        for (int j = 0; j < 3; j++) begin
            wr(`REG_CFG, (j == 2) ? 32'h3 : 32'h1);
            fset(32'h120, (j == 0) ? 32'h5 : 32'h0);
            bus(1'b0, {2'b00, `REG_PC}, 32'h0, pc0);
            exec({`OP_TEST_FILE_SKIP_ZERO_HI, 1'b1, 8'h20});
            bus(1'b0, {2'b00, `REG_PC}, 32'h0, rd);
            dl[j] = rd - pc0;
            cyc[j] = ncyc;
        end
        // Program counter steps one word per instruction cycle, discarded words too
        cmp(dl[0], 32'd2);
        cmp(dl[1], 32'd4);
        cmp(dl[2], 32'd6);
        cmp(cyc[1] - cyc[0], `INSTR_CYCLES);
        cmp(cyc[2] - cyc[1], `INSTR_CYCLES);
        $display("test skip finished");
        wr(`REG_CFG, 32'h1);
        wr(`REG_PTR0, 32'h3ff);
        exec({`OP_FSRADD_HI, 2'd0, 6'h23});
        rchk(`REG_PTR0, 32'hfff, 32'h422);
        wr(`REG_PTR1, 32'h010);
        exec({`OP_FSRSUB_HI, 2'd1, 6'h01});
        rchk(`REG_PTR1, 32'hfff, 32'h00f);
        wr(`REG_RET_ADDR, 32'h1234);
        wr(`REG_PTR2, 32'h100);
        exec({`OP_FSRSUB_HI, 2'd3, 6'h05});
        rchk(`REG_PTR2, 32'hfff, 32'h0fb);
        rchk(`REG_PC, 32'h1fffff, 32'h1234);
        wr(`REG_CFG, 32'h0);
        exec({`OP_FSRADD_HI, 2'd0, 6'h01});
        rchk(`REG_PTR0, 32'hfff, 32'h422);
        $display("test pointer ops finished");
        wr(`REG_TABLE_POINTER_REG, 32'ha356);
        for (int m = 0; m < 4; m++) begin
            exec({`OP_TABLE_WRITE_OP_HI, m[1:0]});
            rchk(`REG_TABLE_POINTER_REG, 32'h3fffff, tb_exp[m]);
        end
        $display("test table write finished");
        finish_test;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test;
    end
endmodule
`default_nettype wire
